// *** common/smc_pkg.sv ***
package smc_pkg;
  // time base
  localparam int          CLK_MHZ        = 10;
  localparam int          TICK_MHZ       = 1;
  localparam logic [3:0]  TICK_DIV       = 4'(CLK_MHZ / TICK_MHZ - 1);
  localparam int          FIRST_CMD_US   = 100;
  localparam int          FIRST_MEAS_US  = 200;
  localparam int          WAKE_CMD_US    = 10;
  localparam int          WAKE_MEAS_US   = 20;
  localparam logic [15:0] FIRST_CMD_TK   = 16'(FIRST_CMD_US * TICK_MHZ);
  localparam logic [15:0] FIRST_MEAS_TK  = 16'(FIRST_MEAS_US * TICK_MHZ);
  localparam logic [15:0] WAKE_CMD_TK    = 16'(WAKE_CMD_US * TICK_MHZ);
  localparam logic [15:0] WAKE_MEAS_TK   = 16'(WAKE_MEAS_US * TICK_MHZ);
  // commands
  localparam logic [7:0]  CMD_RD_LAST    = 8'h3F;
  localparam logic [7:0]  CMD_WR_BASE    = 8'h40;
  localparam logic [7:0]  CMD_WR_LAST    = 8'h78;
  localparam logic [7:0]  CMD_CRC        = 8'h90;
  localparam logic [7:0]  CMD_CM_ENTRY   = 8'hA9;
  localparam logic [7:0]  CMD_MEAS_FIRST = 8'hAA;
  localparam logic [7:0]  CMD_MEAS_LAST  = 8'hAF;
  // nonvolatile store layout
  localparam int          WORD_W         = 16;
  localparam int          MEM_WORDS      = 64;
  localparam int          USER_WORDS     = 57;
  localparam logic [5:0]  CFG_ADDR       = 6'h02;
  localparam logic [5:0]  SMCFG_ADDR     = 6'h12;
  localparam logic [5:0]  THR1_ADDR      = 6'h13;
  localparam logic [5:0]  THR2_ADDR      = 6'h14;
  localparam logic [5:0]  CRC_ADDR       = 6'h3F;
  localparam logic [15:0] BLANK_WORD     = 16'hFFFF;
  localparam int          SS_POL_BIT     = 9;
  localparam int          INT_MSB        = 8;
  localparam int          INT_LSB        = 7;
  localparam int          ABSV_BIT       = 11;
  localparam logic [1:0]  INT_NONE       = 2'h0;
  localparam logic [1:0]  INT_ABOVE      = 2'h1;
  localparam logic [1:0]  INT_BELOW      = 2'h2;
  // link framing and last conversion step
  localparam logic [4:0]  CMD_BITS       = 5'h08;
  localparam logic [4:0]  WR_BITS        = 5'h18;
  localparam logic [1:0]  LAST_STEP      = 2'h3;

  typedef enum logic [6:0] {
    ST_INIT  = 7'h01,
    ST_SLEEP = 7'h02,
    ST_WAKE  = 7'h04,
    ST_IDLE  = 7'h08,
    ST_CONV  = 7'h10,
    ST_CORR  = 7'h20,
    ST_CRC   = 7'h40
  } smc_state_e;

  typedef enum logic [1:0] {
    IF_NONE = 2'h0,
    IF_I2C  = 2'h1,
    IF_SPI  = 2'h2
  } smc_ifmode_e;

  typedef enum logic [1:0] {
    MUX_ANALOG_GROUND   = 2'h0,
    MUX_INPUTS = 2'h1,
    MUX_TEMP   = 2'h2
  } smc_mux_e;

  typedef struct packed {
    smc_state_e  st;
    smc_ifmode_e ifmode;
    smc_mux_e    mux;
    logic [1:0]  step;
    logic [3:0]  div;
    logic        tick;
    logic [15:0] por_cnt;
    logic [15:0] wk_cnt;
    logic        init_done;
    logic        first_seen;
    logic        cmd_mode;
    logic        meas_pend;
    logic [2:0]  tog_s;
    logic [1:0]  sel_s;
    logic [2:0]  xr_s;
    logic        ss_pol;
    logic        eoc;
    logic        busy;
    logic        lv_on;
    logic        conv_start;
    logic        corr_start;
    logic        cfg_temp;
    logic        abs_volt;
    logic        rd_valid;
    logic [15:0] rd_data;
    logic        mem_we;
    logic [5:0]  mem_wa;
    logic [15:0] mem_wd;
    logic [5:0]  crc_idx;
    logic [15:0] crc_sum;
  } smc_core_s;

  typedef struct packed {
    logic [1:0]  pol_s;
    logic [23:0] shift;
    logic [4:0]  bcnt;
    logic [23:0] word;
    logic        via_i2c;
    logic        tog;
  } smc_link_s;

  localparam smc_core_s CORE_RST = '{st: ST_INIT, ifmode: IF_NONE, mux: MUX_ANALOG_GROUND, default: '0};
  localparam smc_link_s LINK_RST = '0;
endpackage : smc_pkg

// *** hw/smc_control.sv ***
`timescale 1ns/10ps
module smc_control (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        external_reset_in,
  input  wire logic        link_clk_in,
  input  wire logic        link_sel_in,
  input  wire logic        link_i2c_in,
  input  wire logic        link_data_in,
  input  wire logic        conv_done_in,
  input  wire logic        corr_done_in,
  input  wire logic [23:0] result_in,
  output logic             conv_start_out,
  output logic [1:0]       mux_sel_out,
  output logic             cfg_temp_out,
  output logic             abs_volt_out,
  output logic             corr_start_out,
  output logic             busy_out,
  output logic             eoc_out,
  output logic             lv_on_out,
  output logic [1:0]       if_mode_out,
  output logic             cmd_mode_out,
  output logic             rd_valid_out,
  output logic [15:0]      rd_data_out
);

  smc_pkg::smc_core_s s;
  smc_pkg::smc_core_s next_s;

  ////////////////////////////////////////////////////////////////////////////
  // link domain

  smc_pkg::smc_link_s l;
  smc_pkg::smc_link_s next_l;
  logic [1:0]         lrst_s;
  logic [1:0]         larm_s;
  logic               l_frame;
  logic [23:0]        l_new;
  logic [4:0]         l_cnt;
  logic               l_is_wr;

  // reset brought into the link clock
  always_ff @(posedge link_clk_in) begin
    lrst_s <= {lrst_s[0], rst_in};
    larm_s <= {larm_s[0], s.init_done};
  end

  always_comb begin
    next_l       = l;
    next_l.pol_s = {l.pol_s[0], s.ss_pol};
    l_frame      = link_i2c_in | (larm_s[1] && (link_sel_in == l.pol_s[1]));
    l_new        = {l.shift[22:0], link_data_in};
    l_cnt        = 5'(l.bcnt + 5'h01);
    l_is_wr      = (l_new[7:0] >= smc_pkg::CMD_WR_BASE) &&
                   (l_new[7:0] <= smc_pkg::CMD_WR_LAST);
    if (!l_frame) begin
      next_l.bcnt = '0;
    end else if (l.bcnt != smc_pkg::WR_BITS) begin
      next_l.shift = l_new;
      next_l.bcnt  = l_cnt;
      // write commands carry a data word after the command byte
      if (l_cnt == smc_pkg::CMD_BITS && !l_is_wr) begin
        next_l.word    = {l_new[7:0], 16'h0000};
        next_l.via_i2c = link_i2c_in;
        next_l.tog     = ~l.tog;
      end else if (l_cnt == smc_pkg::WR_BITS) begin
        next_l.word    = l_new;
        next_l.via_i2c = link_i2c_in;
        next_l.tog     = ~l.tog;
      end
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (lrst_s[1]) begin
      l <= smc_pkg::LINK_RST;
    end else begin
      l <= next_l;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // nonvolatile store

  logic [15:0]                   mem     [smc_pkg::MEM_WORDS];
  logic [15:0]                   mem_rd  [smc_pkg::MEM_WORDS];
  logic [smc_pkg::MEM_WORDS-1:0] mem_vld;

  always_ff @(posedge clk_in) begin
    if (s.mem_we) begin
      mem[s.mem_wa] <= s.mem_wd;
    end
  end

  // words never written read as erased
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mem_vld <= '0;
    end else if (s.mem_we) begin
      mem_vld[s.mem_wa] <= 1'b1;
    end
  end

  always_comb begin
    for (int i = 0; i < smc_pkg::MEM_WORDS; i++) begin
      mem_rd[i] = mem_vld[i] ? mem[i] : smc_pkg::BLANK_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core domain

  logic               cmd_ok;
  logic               meas_ok;
  logic               sel_act;
  logic               new_cmd;
  logic               from_i2c;
  logic               path_ok;
  logic               take;
  logic               start_meas;
  logic               wake_cmd;
  logic [7:0]         cmd;
  logic [15:0]        data;
  logic [15:0]        res_hi;
  logic [15:0]        thr1;
  logic [15:0]        thr2;
  logic [1:0]         int_mode;
  logic               eoc_val;
  logic [1:0]         nstep;

  always_comb begin
    next_s            = s;
    next_s.tick       = (s.div == smc_pkg::TICK_DIV);
    next_s.div        = (s.div == smc_pkg::TICK_DIV) ? 4'h0 : 4'(s.div + 4'h1);
    next_s.tog_s      = {s.tog_s[1:0], l.tog};
    next_s.sel_s      = {s.sel_s[0], link_sel_in};
    next_s.xr_s       = {s.xr_s[1:0], external_reset_in};
    next_s.conv_start = 1'b0;
    next_s.corr_start = 1'b0;
    next_s.rd_valid   = 1'b0;
    next_s.mem_we     = 1'b0;

    if (s.tick && s.por_cnt != smc_pkg::FIRST_MEAS_TK) begin
      next_s.por_cnt = 16'(s.por_cnt + 16'h0001);
    end
    cmd_ok  = (s.por_cnt >= smc_pkg::FIRST_CMD_TK);
    meas_ok = (s.por_cnt == smc_pkg::FIRST_MEAS_TK);

    sel_act  = (s.sel_s[1] == s.ss_pol);
    new_cmd  = s.tog_s[1] ^ s.tog_s[2];
    cmd      = l.word[23:16];
    data     = l.word[15:0];
    from_i2c = l.via_i2c;

    // select only sets spi mode once initiation is over
    if (s.init_done && s.ifmode == smc_pkg::IF_NONE && sel_act) begin
      next_s.ifmode = smc_pkg::IF_SPI;
    end

    unique case (s.ifmode)
      smc_pkg::IF_I2C: path_ok = from_i2c;
      smc_pkg::IF_SPI: path_ok = !from_i2c;
      default:         path_ok = from_i2c ? !sel_act : s.init_done;
    endcase

    wake_cmd = (s.st == smc_pkg::ST_WAKE) && s.cmd_mode &&
               (s.wk_cnt < smc_pkg::WAKE_CMD_TK);
    take     = new_cmd && cmd_ok && path_ok && !wake_cmd;

    // threshold evaluation on corrected result
    res_hi   = result_in[23:8];
    thr1     = mem_rd[smc_pkg::THR1_ADDR];
    thr2     = mem_rd[smc_pkg::THR2_ADDR];
    int_mode = mem_rd[smc_pkg::CFG_ADDR][smc_pkg::INT_MSB:smc_pkg::INT_LSB];
    unique case (int_mode)
      smc_pkg::INT_NONE:  eoc_val = 1'b1;
      smc_pkg::INT_ABOVE: eoc_val = (res_hi > thr1);
      smc_pkg::INT_BELOW: eoc_val = (res_hi < thr1);
      default:            eoc_val = (res_hi < thr1) || (res_hi > thr2);
    endcase

    start_meas = 1'b0;
    nstep      = 2'(s.step + 2'h1);

    unique case (s.st)
      smc_pkg::ST_INIT: begin
        next_s.lv_on = 1'b1;
        if (cmd_ok) begin
          next_s.init_done = 1'b1;
          next_s.ss_pol    = mem_rd[smc_pkg::CFG_ADDR][smc_pkg::SS_POL_BIT];
          next_s.abs_volt  = mem_rd[smc_pkg::SMCFG_ADDR][smc_pkg::ABSV_BIT];
          next_s.lv_on     = 1'b0;
          next_s.st        = smc_pkg::ST_SLEEP;
        end
      end
      smc_pkg::ST_SLEEP: begin
        next_s.lv_on = 1'b0;
      end
      smc_pkg::ST_WAKE: begin
        if (s.tick && s.wk_cnt != smc_pkg::WAKE_MEAS_TK) begin
          next_s.wk_cnt = 16'(s.wk_cnt + 16'h0001);
        end
        if (s.meas_pend) begin
          start_meas = meas_ok && (s.wk_cnt >= smc_pkg::WAKE_MEAS_TK);
        end else if (s.wk_cnt >= smc_pkg::WAKE_CMD_TK) begin
          next_s.st    = s.cmd_mode ? smc_pkg::ST_IDLE : smc_pkg::ST_SLEEP;
          next_s.lv_on = s.cmd_mode;
        end
      end
      smc_pkg::ST_IDLE: begin
        start_meas = s.meas_pend && meas_ok;
      end
      smc_pkg::ST_CONV: begin
        if (conv_done_in) begin
          if (s.step == smc_pkg::LAST_STEP) begin
            next_s.st         = smc_pkg::ST_CORR;
            next_s.corr_start = 1'b1;
          end else begin
            next_s.step       = nstep;
            next_s.conv_start = 1'b1;
            next_s.cfg_temp   = nstep[1];
            next_s.mux        = !nstep[0] ? smc_pkg::MUX_ANALOG_GROUND :
                                nstep[1] ? smc_pkg::MUX_TEMP : smc_pkg::MUX_INPUTS;
          end
        end
      end
      smc_pkg::ST_CORR: begin
        if (corr_done_in) begin
          next_s.eoc   = eoc_val;
          next_s.busy  = 1'b0;
          next_s.st    = s.cmd_mode ? smc_pkg::ST_IDLE : smc_pkg::ST_SLEEP;
          next_s.lv_on = s.cmd_mode;
        end
      end
      smc_pkg::ST_CRC: begin
        next_s.crc_sum = 16'(s.crc_sum + mem_rd[s.crc_idx]);
        next_s.crc_idx = 6'(s.crc_idx + 6'h01);
        if (s.crc_idx == 6'(smc_pkg::CRC_ADDR - 6'h01)) begin
          next_s.mem_we = 1'b1;
          next_s.mem_wa = smc_pkg::CRC_ADDR;
          next_s.mem_wd = 16'(s.crc_sum + mem_rd[s.crc_idx]);
          next_s.st     = s.cmd_mode ? smc_pkg::ST_IDLE : smc_pkg::ST_SLEEP;
          next_s.lv_on  = s.cmd_mode;
        end
      end
      default: begin
        next_s = smc_pkg::CORE_RST;
      end
    endcase

    if (start_meas) begin
      next_s.st         = smc_pkg::ST_CONV;
      next_s.step       = 2'h0;
      next_s.conv_start = 1'b1;
      next_s.mux        = smc_pkg::MUX_ANALOG_GROUND;
      next_s.cfg_temp   = 1'b0;
      next_s.busy       = 1'b1;
      next_s.eoc        = 1'b0;
      next_s.meas_pend  = 1'b0;
      next_s.lv_on      = 1'b1;
      next_s.abs_volt   = mem_rd[smc_pkg::SMCFG_ADDR][smc_pkg::ABSV_BIT];
    end

    if (take) begin
      next_s.first_seen = 1'b1;
      if (s.ifmode == smc_pkg::IF_NONE) begin
        next_s.ifmode = from_i2c ? smc_pkg::IF_I2C : smc_pkg::IF_SPI;
      end
      if (!s.first_seen && cmd == smc_pkg::CMD_CM_ENTRY) begin
        next_s.cmd_mode = 1'b1;
      end
      if (cmd <= smc_pkg::CMD_RD_LAST) begin
        next_s.rd_valid = 1'b1;
        next_s.rd_data  = mem_rd[cmd[5:0]];
      end else if (cmd >= smc_pkg::CMD_WR_BASE && cmd <= smc_pkg::CMD_WR_LAST) begin
        next_s.mem_we = 1'b1;
        next_s.mem_wa = 6'(cmd - smc_pkg::CMD_WR_BASE);
        next_s.mem_wd = data;
      end else if (cmd == smc_pkg::CMD_CRC &&
                   (s.st == smc_pkg::ST_SLEEP || s.st == smc_pkg::ST_IDLE)) begin
        next_s.st      = smc_pkg::ST_CRC;
        next_s.crc_idx = 6'h00;
        next_s.crc_sum = 16'h0000;
        next_s.lv_on   = 1'b1;
      end else if (cmd >= smc_pkg::CMD_MEAS_FIRST && cmd <= smc_pkg::CMD_MEAS_LAST) begin
        next_s.meas_pend = 1'b1;
      end
      // activating commands leave sleep through the wake delay
      if (s.st == smc_pkg::ST_SLEEP && (cmd == smc_pkg::CMD_CM_ENTRY ||
          (cmd >= smc_pkg::CMD_MEAS_FIRST && cmd <= smc_pkg::CMD_MEAS_LAST))) begin
        next_s.st     = smc_pkg::ST_WAKE;
        next_s.wk_cnt = 16'h0000;
        next_s.lv_on  = 1'b1;
      end
    end

    // falling edge on the external reset restarts power-up
    if (s.xr_s[2] && !s.xr_s[1]) begin
      next_s       = smc_pkg::CORE_RST;
      next_s.tog_s = {s.tog_s[1:0], l.tog};
      next_s.xr_s  = {s.xr_s[1:0], external_reset_in};
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= smc_pkg::CORE_RST;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign conv_start_out = s.conv_start;
  assign mux_sel_out    = s.mux;
  assign cfg_temp_out   = s.cfg_temp;
  assign abs_volt_out   = s.abs_volt;
  assign corr_start_out = s.corr_start;
  assign busy_out       = s.busy;
  assign eoc_out        = s.eoc;
  assign lv_on_out      = s.lv_on;
  assign if_mode_out    = s.ifmode;
  assign cmd_mode_out   = s.cmd_mode;
  assign rd_valid_out   = s.rd_valid;
  assign rd_data_out    = s.rd_data;

endmodule : smc_control

// *** verification/smc_control_asserts.sv ***
`timescale 1ns/10ps
module smc_control_asserts (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       conv_done_in,
  input wire logic       corr_done_in,
  input wire logic       conv_start_out,
  input wire logic [1:0] mux_sel_out,
  input wire logic       cfg_temp_out,
  input wire logic       corr_start_out,
  input wire logic       busy_out,
  input wire logic       eoc_out,
  input wire logic       lv_on_out,
  input wire logic [1:0] if_mode_out,
  input wire logic       cmd_mode_out
);
  localparam int INIT_CYC = 900;
  logic [15:0] run_cnt;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // cycles since power-on reset, saturating
  always_ff @(posedge clk_in) begin
    if (rst_in) run_cnt <= 16'h0000;
    else if (run_cnt != 16'hFFFF) run_cnt <= run_cnt + 16'h0001;
  end
  ////////////////////////////////////////
  a_init_quiet: assert property (run_cnt < INIT_CYC |-> if_mode_out == 2'h0 && !busy_out)
    else $error("interface or measurement active during initiation");
  a_first_step: assert property (conv_start_out && !$past(busy_out) |->
    mux_sel_out == 2'h0 && !cfg_temp_out && !eoc_out && busy_out)
    else $error("bad first conversion step");
  a_zero_to_sensor: assert property (conv_done_in && busy_out && mux_sel_out == 2'h0 &&
    !cfg_temp_out |=> conv_start_out && mux_sel_out == 2'h1 && !cfg_temp_out)
    else $error("sensor step not started after sensor zero");
  a_sensor_to_tzero: assert property (conv_done_in && busy_out && mux_sel_out == 2'h1 |=>
    conv_start_out && mux_sel_out == 2'h0 && cfg_temp_out)
    else $error("temperature zero step not started");
  a_tzero_to_temp: assert property (conv_done_in && busy_out && mux_sel_out == 2'h0 &&
    cfg_temp_out |=> conv_start_out && mux_sel_out == 2'h2 && cfg_temp_out)
    else $error("temperature step not started");
  a_temp_to_corr: assert property (conv_done_in && busy_out && mux_sel_out == 2'h2 |=>
    corr_start_out && busy_out)
    else $error("correction not started after last step");
  a_busy_hold: assert property (busy_out && !corr_done_in |=> busy_out)
    else $error("busy dropped before correction done");
  a_done_ends: assert property (busy_out && corr_done_in |=>
    !busy_out && lv_on_out == cmd_mode_out)
    else $error("busy or power wrong after correction");
  a_eoc_cause: assert property ($rose(eoc_out) |-> $past(corr_done_in))
    else $error("conversion done raised without correction done");
  a_i2c_kept: assert property (if_mode_out == 2'h1 |=> if_mode_out != 2'h2)
    else $error("interface switched from i2c to spi");
endmodule : smc_control_asserts

bind smc_control smc_control_asserts i_smc_control_asserts (
  .clk_in(clk_in), .rst_in(rst_in), .conv_done_in(conv_done_in),
  .corr_done_in(corr_done_in), .conv_start_out(conv_start_out), .mux_sel_out(mux_sel_out),
  .cfg_temp_out(cfg_temp_out), .corr_start_out(corr_start_out), .busy_out(busy_out),
  .eoc_out(eoc_out), .lv_on_out(lv_on_out), .if_mode_out(if_mode_out),
  .cmd_mode_out(cmd_mode_out)
);

// *** verification/smc_host_model.sv ***
`timescale 1ns/10ps
module smc_host_model (
  output logic link_clk_out,
  output logic link_sel_out,
  output logic link_i2c_out,
  output logic link_data_out
);
  initial begin
    link_clk_out  = 1'b0;
    link_sel_out  = 1'b0;
    link_i2c_out  = 1'b0;
    link_data_out = 1'b1;
  end
  ////////////////////////////////////////
  // clock edges with no frame, only to clock in the link reset
  task automatic flush(input int n);
    repeat (n) begin
      #16 link_clk_out = 1'b1;
      #16 link_clk_out = 1'b0;
    end
  endtask : flush
  // command byte, then data word msb first when writing
  task automatic frame(input logic spi, input logic [7:0] cmd, input logic wr,
                       input logic [15:0] data);
    logic [23:0] bits;
    bits = {cmd, data};
    link_sel_out = spi;
    link_i2c_out = ~spi;
    for (int i = 23; i >= (wr ? 0 : 16); i--) begin
      link_data_out = bits[i];
      #16 link_clk_out = 1'b1;
      #16 link_clk_out = 1'b0;
    end
    #16;
    link_sel_out  = 1'b0;
    link_i2c_out  = 1'b0;
    link_data_out = spi ? ~link_data_out : 1'b1;
    // one idle edge closes the frame at the link
    #16 link_clk_out = 1'b1;
    #16 link_clk_out = 1'b0;
  endtask : frame
  // select toggled with no clock
  task automatic sel_pulse();
    link_sel_out = 1'b1;
    #200 link_sel_out = 1'b0;
  endtask : sel_pulse
endmodule : smc_host_model

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  typedef struct packed {
    logic [1:0]  mode;
    logic [23:0] res;
    logic        eoc;
  } smc_row_s;
  localparam smc_row_s ROWS [6] = '{'{2'h0, 24'h700000, 1'b1}, '{2'h1, 24'h900000, 1'b1},
    '{2'h1, 24'h700000, 1'b0}, '{2'h2, 24'h700000, 1'b1}, '{2'h3, 24'hD00000, 1'b1},
    '{2'h3, 24'hA00000, 1'b0}};
  localparam logic [23:0] WRS [6] = '{24'h420200, 24'h52F800, 24'h538000, 24'h54C000,
    24'h45A5C3, 24'h781234};
  localparam logic [8:0] STEP_EXP = 9'b101_001_010;
  logic        clk_in;
  logic        rst_in;
  logic        external_reset_in;
  logic        conv_done_in;
  logic        corr_done_in;
  logic [23:0] result_in;
  logic        link_clk, link_sel, link_i2c, link_data;
  logic        conv_start, corr_start, cfg_temp, abs_volt, busy, eoc, lv_on, cmd_mode;
  logic        rd_valid;
  logic [1:0]  mux_sel, if_mode;
  logic [15:0] rd_data;
  int          bad_count;
  int          check_count;

  smc_control i_smc_control (.clk_in(clk_in), .rst_in(rst_in),
    .external_reset_in(external_reset_in), .link_clk_in(link_clk), .link_sel_in(link_sel),
    .link_i2c_in(link_i2c), .link_data_in(link_data), .conv_done_in(conv_done_in),
    .corr_done_in(corr_done_in), .result_in(result_in), .conv_start_out(conv_start),
    .mux_sel_out(mux_sel), .cfg_temp_out(cfg_temp), .abs_volt_out(abs_volt),
    .corr_start_out(corr_start), .busy_out(busy), .eoc_out(eoc), .lv_on_out(lv_on),
    .if_mode_out(if_mode), .cmd_mode_out(cmd_mode), .rd_valid_out(rd_valid),
    .rd_data_out(rd_data));
  smc_host_model i_smc_host_model (.link_clk_out(link_clk), .link_sel_out(link_sel),
    .link_i2c_out(link_i2c), .link_data_out(link_data));

  always #50 clk_in = ~clk_in;
  ////////////////////////////////////////
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask : tick
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_out(input int which, input int lim);
    logic [2:0] outs;
    for (int i = 0; i < lim; i++) begin
      tick();
      outs = {rd_valid, corr_start, conv_start};
      if (outs[which] === 1'b1) break;
    end
  endtask : wait_out
  task automatic rd_chk(input logic spi, input logic [7:0] cmd, input logic [15:0] exp);
    i_smc_host_model.frame(spi, cmd, 1'b0, 16'h0000);
    wait_out(2, 20);
    chk({rd_valid, rd_data}, {1'b1, exp});
    repeat (6) tick();
  endtask : rd_chk
  task automatic measure(input logic [23:0] res, input logic exp_eoc);
    i_smc_host_model.frame(1'b0, 8'hAA, 1'b0, 16'h0000);
    wait_out(0, 400);
    chk({conv_start, busy, eoc, abs_volt, mux_sel, cfg_temp}, 7'b1101_00_0);
    for (int k = 1; k < 4; k++) begin
      repeat (3) tick();
      conv_done_in = 1'b1;
      tick();
      conv_done_in = 1'b0;
      chk({conv_start, mux_sel, cfg_temp}, {1'b1, STEP_EXP[k*3-3 +: 3]});
    end
    repeat (3) tick();
    conv_done_in = 1'b1;
    tick();
    conv_done_in = 1'b0;
    chk({corr_start, busy}, 2'b11);
    repeat (3) tick();
    result_in = res;
    corr_done_in = 1'b1;
    tick();
    corr_done_in = 1'b0;
    chk({busy, eoc, lv_on}, {1'b0, exp_eoc, 1'b0});
    repeat (10) tick();
  endtask : measure
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  initial begin
    #2_000_000;
    bad_count++;
    test_done();
  end

  initial begin
    clk_in = 1'b0;
    rst_in = 1'b1;
    external_reset_in = 1'b1;
    conv_done_in = 1'b0;
    corr_done_in = 1'b0;
    result_in = 24'h000000;
    bad_count = 0;
    check_count = 0;
    i_smc_host_model.flush(8);
    tick();
    rst_in = 1'b0;
    chk({busy, eoc, conv_start, if_mode, cmd_mode, rd_valid}, 7'h00);
    tick();
    chk(lv_on, 1'b1);
    repeat (200) tick();
    i_smc_host_model.sel_pulse();
    i_smc_host_model.frame(1'b0, 8'h05, 1'b0, 16'h0000);
    repeat (10) tick();
    chk({if_mode, rd_valid}, 3'h0);
    repeat (900) tick();
    foreach (WRS[i]) begin
      i_smc_host_model.frame(1'b0, WRS[i][23:16], 1'b1, WRS[i][15:0]);
      repeat (10) tick();
    end
    chk(if_mode, 2'h1);
    i_smc_host_model.frame(1'b0, 8'h90, 1'b0, 16'h0000);
    repeat (80) tick();
    rd_chk(1'b0, 8'h3F, 16'hF1BE);
    rd_chk(1'b0, 8'h02, 16'h0200);
    rd_chk(1'b0, 8'h05, 16'hA5C3);
    rd_chk(1'b0, 8'h38, 16'h1234);
    repeat (800) tick();
    foreach (ROWS[i]) begin
      i_smc_host_model.frame(1'b0, 8'h42, 1'b1, {7'h01, ROWS[i].mode, 7'h00});
      repeat (10) tick();
      measure(ROWS[i].res, ROWS[i].eoc);
    end
    i_smc_host_model.frame(1'b1, 8'h05, 1'b0, 16'h0000);
    wait_out(2, 20);
    chk({if_mode, rd_valid}, {2'h1, 1'b0});
    external_reset_in = 1'b0;
    repeat (3) tick();
    external_reset_in = 1'b1;
    repeat (6) tick();
    chk({if_mode, lv_on, busy, eoc}, 5'b00_1_00);
    repeat (100) tick();
    i_smc_host_model.sel_pulse();
    repeat (5) tick();
    chk(if_mode, 2'h0);
    repeat (1100) tick();
    rd_chk(1'b1, 8'h05, 16'hA5C3);
    chk(if_mode, 2'h2);
    i_smc_host_model.frame(1'b1, 8'hA9, 1'b0, 16'h0000);
    repeat (10) tick();
    chk(cmd_mode, 1'b0);
    test_done();
  end
endmodule : tb_top
